// File: hdl/epd_serial_host_port.sv
// write-only serial host port: pin sampling, word assembly, routing
`include "epd_port_consts.svh"
module epd_serial_host_port (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reset_n_pin,
    input wire logic bus_mode_strap,
    input wire logic chip_sel_n,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    input wire logic dc_sel,
    output logic sdo_out,
    output logic sdo_oe,
    output logic overrun,
    output logic ram_wr,
    output logic cmd_wr,
    output logic [7:0] wr_byte,
    input wire logic sink_ready
);
    typedef struct packed {
        logic sclk_prev;
        logic [3:0] bit_cnt;
        logic [8:0] shreg;
        logic word_vld;
        logic [8:0] word;
        logic ovr;
        logic ram_wr;
        logic cmd_wr;
        logic [7:0] wr_byte;
        logic rst_pin_q;
    } port_state_t;
    port_state_t s_q, s_d;

    logic [4:0] pins;
    logic sclk_s, sdi_s, csn_s, dc_s, mode_s;
    logic rise;
    logic full_word;
    logic [3:0] need;
    logic [8:0] next_sh;
    logic [8:0] word_in;
    logic fifo_in_ready, f_valid;
    logic [8:0] f_data;
    logic soft_rst_n;
    logic take;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    epd_sync2 #(.W(5)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in({serial_clk, serial_data_in, chip_sel_n, dc_sel, bus_mode_strap}),
        .sync_out(pins)
    );
    assign {sclk_s, sdi_s, csn_s, dc_s, mode_s} = pins;

    // reset pin also synchronised; low holds the port in reset
    logic [0:0] rstp_s;
    epd_sync2 #(.W(1)) u_sync_rst (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(reset_n_pin),
        .sync_out(rstp_s)
    );
    assign soft_rst_n = rst_n && s_q.rst_pin_q;

    // ----------------------------------------
    // word framing
    // ----------------------------------------
    function automatic logic [3:0] bits_for(input logic m);
        bits_for = (m == epd_port_pkg::MODE_3W) ? `EPD_BITS_3W : `EPD_BITS_4W;
    endfunction

    assign rise = sclk_s && !s_q.sclk_prev && !csn_s;
    assign need = bits_for(mode_s);
    assign next_sh = {s_q.shreg[7:0], sdi_s};
    // at or past the last bit, so a strap flip mid-word cannot run the count away
    assign full_word = rise && (s_q.bit_cnt >= need - 4'h1);
    // 4-wire: flag is the pin sampled on the eighth clock; 3-wire: the first bit
    assign word_in = (mode_s == epd_port_pkg::MODE_3W) ? next_sh
                   : {dc_s, next_sh[7:0]};

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rst_pin_q = rstp_s[0];
        s_d.sclk_prev = sclk_s;
        s_d.word_vld = 1'b0;
        s_d.ram_wr = 1'b0;
        s_d.cmd_wr = 1'b0;
        if (csn_s) begin
            s_d.bit_cnt = 4'h0;
            s_d.shreg = '0;
        end else if (rise) begin
            if (full_word) begin
                s_d.bit_cnt = 4'h0;
                s_d.word_vld = 1'b1;
                s_d.word = word_in;
            end else begin
                s_d.bit_cnt = s_q.bit_cnt + 4'h1;
            end
            s_d.shreg = next_sh;
        end
        // word dropped when the fifo is full; sticky until reset
        if (s_q.word_vld && !fifo_in_ready) begin
            s_d.ovr = 1'b1;
        end
        // strobe only on a real pop, so a stalled word is neither lost nor repeated
        if (take) begin
            s_d.ram_wr = f_data[8];
            s_d.cmd_wr = !f_data[8];
            s_d.wr_byte = f_data[7:0];
        end
        // pin reset clears all but its own flop, which must see the pin come back
        if (!soft_rst_n) begin
            s_d = '0;
            s_d.rst_pin_q = rstp_s[0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // fifo between the serial side and the sinks
    // ----------------------------------------
    epd_fifo #(.WIDTH(`EPD_WORD_W), .DEPTH(`EPD_FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(soft_rst_n),
        .in_valid(s_q.word_vld),
        .in_ready(fifo_in_ready),
        .in_data(s_q.word),
        .out_valid(f_valid),
        .out_ready(sink_ready),
        .out_data(f_data)
    );

    // write-only port: output pin never enabled
    assign sdo_out = 1'b0;
    assign sdo_oe = 1'b0;
    assign overrun = s_q.ovr;
    assign ram_wr = s_q.ram_wr;
    assign cmd_wr = s_q.cmd_wr;
    // a word leaves the fifo only when the sink takes it
    assign take = f_valid && sink_ready;
    assign wr_byte = s_q.wr_byte;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_no_drive;
        @(posedge sys_clk) disable iff (!rst_n) !sdo_oe;
    endproperty
    a_no_drive: assert property (p_no_drive) else $error("sdo driven");

    property p_cs_clear;
        @(posedge sys_clk) disable iff (!soft_rst_n) csn_s |=> s_q.bit_cnt == 4'h0;
    endproperty
    a_cs_clear: assert property (p_cs_clear) else $error("count kept");

    property p_no_word_idle;
        @(posedge sys_clk) disable iff (!soft_rst_n) csn_s |=> !s_q.word_vld;
    endproperty
    a_no_word_idle: assert property (p_no_word_idle) else $error("word w/o cs");

    property p_len_4w;
        @(posedge sys_clk) disable iff (!soft_rst_n)
            (s_q.word_vld && mode_s == 1'b0) |-> $past(s_q.bit_cnt) == 4'h7;
    endproperty
    a_len_4w: assert property (p_len_4w) else $error("4w length");

    property p_len_3w;
        @(posedge sys_clk) disable iff (!soft_rst_n)
            (s_q.word_vld && mode_s == 1'b1) |-> $past(s_q.bit_cnt) == 4'h8;
    endproperty
    a_len_3w: assert property (p_len_3w) else $error("3w length");

    property p_dc_4w;
        @(posedge sys_clk) disable iff (!soft_rst_n)
            (full_word && mode_s == 1'b0) |=> s_q.word[8] == $past(dc_s);
    endproperty
    a_dc_4w: assert property (p_dc_4w) else $error("dc sample");

    property p_flag_3w;
        @(posedge sys_clk) disable iff (!soft_rst_n)
            (full_word && mode_s == 1'b1) |=> s_q.word[8] == $past(s_q.shreg[7]);
    endproperty
    a_flag_3w: assert property (p_flag_3w) else $error("flag bit");

    property p_route;
        @(posedge sys_clk) disable iff (!soft_rst_n)
            take |=> (s_q.ram_wr == $past(f_data[8])) && (s_q.cmd_wr != s_q.ram_wr);
    endproperty
    a_route: assert property (p_route) else $error("routing");

    property p_reset;
        @(posedge sys_clk) !rst_n |=> s_q.bit_cnt == 4'h0 && !s_q.ovr;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state");

    // a pin reset leaves the counter and the strobes clear
    property p_pin_reset;
        @(posedge sys_clk) disable iff (!rst_n)
            !s_q.rst_pin_q |=> s_q.bit_cnt == 4'h0 && !s_q.ram_wr && !s_q.cmd_wr;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset");

    // any reset empties the fifo by the next edge
    property p_fifo_clear;
        @(posedge sys_clk)
            !soft_rst_n |=> !f_valid;
    endproperty
    a_fifo_clear: assert property (p_fifo_clear) else $error("fifo kept");

    // a strobe only follows a word taken from the fifo
    property p_wr_take;
        @(posedge sys_clk) disable iff (!soft_rst_n)
            (ram_wr || cmd_wr) |-> $past(take);
    endproperty
    a_wr_take: assert property (p_wr_take) else $error("stray write");

    // the byte shown is the one popped
    property p_byte;
        @(posedge sys_clk) disable iff (!soft_rst_n)
            take |=> wr_byte == $past(f_data[7:0]);
    endproperty
    a_byte: assert property (p_byte) else $error("byte value");

    // the byte holds between pops
    property p_byte_hold;
        @(posedge sys_clk) disable iff (!soft_rst_n)
            !take |=> $stable(wr_byte);
    endproperty
    a_byte_hold: assert property (p_byte_hold) else $error("byte moved");

    // a finished 3-wire word is the nine shifted bits
    property p_word_3w;
        @(posedge sys_clk) disable iff (!soft_rst_n)
            (full_word && mode_s == 1'b1) |=> s_q.word == $past(next_sh);
    endproperty
    a_word_3w: assert property (p_word_3w) else $error("3w word");

    // a finished 4-wire word keeps the eight shifted bits
    property p_word_4w;
        @(posedge sys_clk) disable iff (!soft_rst_n)
            (full_word && mode_s == 1'b0) |=> s_q.word[7:0] == $past(next_sh[7:0]);
    endproperty
    a_word_4w: assert property (p_word_4w) else $error("4w word");

    // each detected edge shifts one bit in
    property p_shift;
        @(posedge sys_clk) disable iff (!soft_rst_n)
            rise |=> s_q.shreg == $past(next_sh);
    endproperty
    a_shift: assert property (p_shift) else $error("shift");

    // the count steps by one on an edge that does not end the word
    property p_cnt_step;
        @(posedge sys_clk) disable iff (!soft_rst_n)
            (rise && !full_word) |=> s_q.bit_cnt == $past(s_q.bit_cnt) + 4'h1;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("count step");

    // while selected and without an edge the count stands
    property p_cnt_hold;
        @(posedge sys_clk) disable iff (!soft_rst_n)
            (!csn_s && !rise) |=> $stable(s_q.bit_cnt);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("count moved");

    // the count never passes the last bit of a nine-bit word
    property p_cnt_range;
        @(posedge sys_clk) disable iff (!soft_rst_n)
            s_q.bit_cnt <= 4'h8;
    endproperty
    a_cnt_range: assert property (p_cnt_range) else $error("count range");

    // a word met by a full fifo raises overrun
    property p_ovr_set;
        @(posedge sys_clk) disable iff (!soft_rst_n)
            (s_q.word_vld && !fifo_in_ready) |=> overrun;
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun missed");

    // overrun stays until a reset
    property p_ovr_sticky;
        @(posedge sys_clk) disable iff (!soft_rst_n)
            overrun |=> overrun;
    endproperty
    a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun lost");

    // main scenarios seen at least once
    c_word_4w: cover property (@(posedge sys_clk) s_q.word_vld && !mode_s);
    c_word_3w: cover property (@(posedge sys_clk) s_q.word_vld && mode_s);
    c_abort: cover property (@(posedge sys_clk) csn_s && s_q.bit_cnt != 4'h0);
    c_full: cover property (@(posedge sys_clk) !fifo_in_ready);
    c_pin_reset: cover property (@(posedge sys_clk) rst_n && !rstp_s[0]);
endmodule // epd_serial_host_port

// File: hdl/epd_port_consts.svh
// constants of the serial host port
// Contract
// - strap low picks 4-wire 8-bit mode, strap high picks 3-wire 9-bit mode
// - in 3-wire mode the command/data pin is ignored; host ties it low
// - 4-wire mode shifts data in on rising clock, msb first, eight bits
// - 4-wire mode samples command/data pin on eighth clock and commits byte then
// - port is write only and never drives data back
// - 3-wire mode shifts nine bits, flag first then msb to lsb
// - 3-wire flag 1 routes byte to display ram, 0 to command register
// - serial lines accepted only while chip select is low
// - low reset returns port to its initial state
`ifndef EPD_PORT_CONSTS_SVH
`define EPD_PORT_CONSTS_SVH
`define EPD_BITS_4W 4'h8
`define EPD_BITS_3W 4'h9
`define EPD_FIFO_DEPTH 8
`define EPD_WORD_W 9
`endif

// File: hdl/epd_port_pkg.sv
// types of the serial host port
package epd_port_pkg;
    typedef enum logic [0:0] {
        MODE_4W = 1'b0,
        MODE_3W = 1'b1
    } bus_mode_t;
endpackage

// File: hdl/epd_sync2.sv
// two-stage synchroniser for a bundle of pin levels
module epd_sync2 #(
    parameter int W = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sync_state_t;
    sync_state_t s_q, s_d;

    // ----------------------------------------
    // two flops, the first read only by the second
    // ----------------------------------------
    always_comb begin
        s_d.meta = async_in;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.sync;
endmodule // epd_sync2

// File: hdl/epd_fifo.sv
// small valid/ready fifo for received words
module epd_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_state_t;
    fifo_state_t s_q, s_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign out_data = mem[s_q.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // ----------------------------------------
    // pointer and count update
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // storage has no reset, only written on push
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[s_q.wp] <= in_data;
        end
    end
endmodule // epd_fifo

// File: verif/epd_host_model.sv
// behavioural host that writes words into the serial host port
module epd_host_model (
    input wire logic sys_clk,
    output logic chip_sel_n,
    output logic serial_clk,
    output logic serial_data_in,
    output logic dc_sel
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle: select high, clock parked low, pins start quiet
    initial begin
        chip_sel_n = 1'b1;
        serial_clk = 1'b0;
        serial_data_in = 1'b0;
        dc_sel = 1'b0;
    end

    // half of the 160 ns link period at 8 ns
    task automatic half();
        repeat (10) @(posedge sys_clk);
    endtask

    // ---------------------------------------------------------------
    // one frame; nbits below the word size gives an aborted word
    // the port has no busy line, so the host never has to hold off
    // ---------------------------------------------------------------
    task automatic send(input logic three_w, input logic flag, input logic [7:0] data,
                        input int nbits, input logic sel_on);
        logic [8:0] w;
        w = three_w ? {flag, data} : {data, 1'b0};
        chip_sel_n <= ~sel_on;
        dc_sel <= three_w ? 1'b0 : flag;
        half();
        for (int i = 0; i < nbits; i++) begin
            serial_data_in <= w[8-i];
            half();
            serial_clk <= 1'b1;
            half();
            serial_clk <= 1'b0;
        end
        half();
        chip_sel_n <= 1'b1;
        // released data line, and in 4-wire mode the dc line, do not keep their last level
        serial_data_in <= ~serial_data_in;
        dc_sel <= three_w ? 1'b0 : ~dc_sel;
        half();
    endtask
endmodule // epd_host_model

// File: verif/epd_serial_host_port_bench.sv
// self-checking bench of the serial host port
module epd_serial_host_port_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk, rst_n, reset_n_pin, bus_mode_strap, sink_ready;
    logic chip_sel_n, serial_clk, serial_data_in, dc_sel;
    logic sdo_out, sdo_oe, overrun, ram_wr, cmd_wr;
    logic [7:0] wr_byte;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    logic rnd_on, hold_val;
    logic [7:0] b;
    int err_count, cmp_count;
    int seed = 84;

    // ---------------------------------------------------------------
    // clock, host model and device
    // ---------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    epd_host_model u_host (.sys_clk(sys_clk), .chip_sel_n(chip_sel_n),
        .serial_clk(serial_clk), .serial_data_in(serial_data_in), .dc_sel(dc_sel));

    epd_serial_host_port u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reset_n_pin(reset_n_pin),
        .bus_mode_strap(bus_mode_strap), .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
        .serial_data_in(serial_data_in), .dc_sel(dc_sel), .sdo_out(sdo_out),
        .sdo_oe(sdo_oe), .overrun(overrun), .ram_wr(ram_wr), .cmd_wr(cmd_wr),
        .wr_byte(wr_byte), .sink_ready(sink_ready));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // note the expected write, then have the host send it whole
    task automatic word(input logic flag, input logic [7:0] d);
        exp_q.push_back({6'h00, flag, ~flag, d});
        u_host.send(bus_mode_strap, flag, d, bus_mode_strap ? 9 : 8, 1'b1);
    endtask

    // bounded wait until every noted write has come out
    task automatic drain();
        for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge sys_clk);
    endtask

    // random stalls from the consumer keep the fifo busy
    always @(posedge sys_clk) begin
        sink_ready <= rnd_on ? 1'($random(seed)) : hold_val;
    end

    // monitor: each write pulse is matched to the oldest note
    always @(posedge sys_clk) begin
        if (rst_n && (ram_wr === 1'b1 || cmd_wr === 1'b1)) begin
            e = (exp_q.size() != 0) ? exp_q.pop_front() : 16'hFFFF;
            check({6'h00, ram_wr, cmd_wr, wr_byte}, e);
            check({14'h0000, sdo_oe, sdo_out}, 16'h0000);
        end
    end

    // watchdog well beyond the expected run length
    initial begin
        #400us;
        err_count++;
        test_done();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        reset_n_pin = 1'b1;
        bus_mode_strap = 1'b0;
        rnd_on = 1'b0;
        hold_val = 1'b1;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check({14'h0000, ram_wr, cmd_wr}, 16'h0000);
        rnd_on <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            bus_mode_strap <= 1'(m);
            repeat (8) @(posedge sys_clk);
            for (int k = 0; k < 6; k++) begin
                b = 8'($random(seed));
                word(k[0], (k == 0) ? 8'hFF : b);
            end
            // aborted word and traffic while deselected leave nothing behind
            u_host.send(bus_mode_strap, 1'b1, 8'hA5, 5, 1'b1);
            u_host.send(bus_mode_strap, 1'b0, 8'h3C, bus_mode_strap ? 9 : 8, 1'b0);
            word(1'b0, 8'h81);
            // reset pin once the queue is empty, then traffic resumes
            drain();
            reset_n_pin <= 1'b0;
            repeat (6) @(posedge sys_clk);
            reset_n_pin <= 1'b1;
            repeat (8) @(posedge sys_clk);
            word(1'b1, 8'h00);
            drain();
        end
        // stalled consumer: eight words wait in the fifo, none lost
        rnd_on <= 1'b0;
        hold_val <= 1'b0;
        for (int k = 0; k < 8; k++) word(k[1], 8'(k * 37));
        check({15'h0000, overrun}, 16'h0000);
        // a ninth word finds the fifo full: dropped, not noted, flagged
        u_host.send(bus_mode_strap, 1'b1, 8'h5A, bus_mode_strap ? 9 : 8, 1'b1);
        check({15'h0000, overrun}, 16'h0001);
        hold_val <= 1'b1;
        drain();
        check(16'(exp_q.size()), 16'h0000);
        // mid-run reset clears the sticky flag, then one more word passes
        rst_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check({15'h0000, overrun}, 16'h0000);
        word(1'b0, 8'hC3);
        drain();
        check(16'(exp_q.size()), 16'h0000);
        test_done();
    end
endmodule // epd_serial_host_port_bench
